//--- design/acr_frame_ready.sv
// Conversion-ready output and serial frame logic, top level
`timescale 1ns/10ps
`default_nettype none
module acr_frame_ready
  import acr_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_MCLK_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        din_i,
  output logic             dout_o,
  output logic             dout_oe_o,
  output logic             conversion_ready_n_o,
  output logic             conversion_ready_oe_o,
  input  wire logic [1:0]  ch_result_i,
  input  wire logic [23:0] ch0_data_i,
  input  wire logic [23:0] ch1_data_i,
  input  wire logic [9:0]  ch0_phase_offset_i,
  input  wire logic [9:0]  ch1_phase_offset_i,
  input  wire logic        restart_i,
  input  wire logic        global_chop_i,
  input  wire logic        current_detect_i,
  input  wire logic        cd_hit_i,
  input  wire logic [2:0]  oversampling_ratio_i,
  input  wire logic [1:0]  ready_source_select_i,
  input  wire logic        ready_open_drain_i,
  input  wire logic        ready_pulse_format_i,
  input  wire logic [1:0]  word_length_sel_i,
  input  wire logic        timeout_en_i,
  input  wire logic [15:0] resp_word_i,
  input  wire logic [15:0] crc_word_i,
  input  wire logic [15:0] extra_word_i,
  output logic [15:0]      cmd_word_o,
  output logic             cmd_valid_o,
  output logic [7:0]       word_index_o,
  output logic [1:0]       data_flags_o
);
  // Pin synchronisation
  logic [2:0] pins_s;
  acr_sync #(.WIDTH(3)) u_sync (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   ({sclk_i, cs_n_i, din_i}),
    .sync_o    (pins_s)
  );
  wire s_sclk = pins_s[2];
  wire s_cs_n = pins_s[1];
  wire s_din  = pins_s[0];

  logic        sclk_prev_reg;
  logic        cs_prev_reg;
  logic [4:0]  bit_cnt_reg;
  logic [7:0]  word_idx_reg;
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic        dout_reg;
  logic [15:0] cmd_hold_reg;
  logic        cmd_got_reg;
  logic [15:0] prev_cmd_reg;
  logic        cmd_valid_reg;
  logic        started_reg;
  logic [15:0] to_cnt_reg;
  logic        arm_reg;
  logic [1:0]  flags_reg;
  logic [1:0]  wlen_reg;

  // Selected for two samples: synchroniser resets SCLK high,
  // so the first sample after reset could look like a rising edge
  wire cs_active = !s_cs_n && !cs_prev_reg;
  wire sclk_rise = s_sclk && !sclk_prev_reg && cs_active;
  wire sclk_fall = !s_sclk && sclk_prev_reg && cs_active;
  wire cs_rise   = s_cs_n && !cs_prev_reg;

  // Word length, decoded from the held copy
  wire [4:0] last_bit = (wlen_reg == WLEN_16) ? LAST_BIT_16 :
                        (wlen_reg == WLEN_24) ? LAST_BIT_24 : LAST_BIT_32;
  wire word_done = sclk_fall && (bit_cnt_reg == last_bit);

  // Timeout from first SCLK; counted in master clock cycles
  wire to_hit = timeout_en_i && started_reg && !s_cs_n &&
                (to_cnt_reg == 16'(TIMEOUT_CYC - 1));
  wire ser_reset = s_cs_n || to_hit;

  // Status word: flags low, held word length above
  wire [15:0] status_word = {6'h00, wlen_reg, 6'h00, flags_reg};
  wire [15:0] resp16 = (prev_cmd_reg == CMD_NULL) ? status_word : resp_word_i;

  // Per-channel data formatting, left justified in 32 bits except WLEN_32S, which is sign extended and right justified
  wire [23:0] ch_data [2];
  wire [31:0] ch_word [2];
  assign ch_data[0] = ch0_data_i;
  assign ch_data[1] = ch1_data_i;
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      assign ch_word[c] = (wlen_reg == WLEN_16)  ? {ch_data[c][23:8], ZERO16} :
                          (wlen_reg == WLEN_32S) ? {{8{ch_data[c][23]}}, ch_data[c]} :
                                                   {ch_data[c], ZERO8};
      // Set wins over clear
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          flags_reg[c] <= 1'b0;
        end else if (ch_result_i[c]) begin
          flags_reg[c] <= 1'b1;
        end else if (word_done && word_idx_reg == WORD_CH0 + 8'(c)) begin
          flags_reg[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // Word selection for the next launch
  wire [31:0] next_word = (word_idx_reg == WORD_RESP) ? {resp16, ZERO16} :
                          (word_idx_reg == WORD_CH0)  ? ch_word[0] :
                          (word_idx_reg == WORD_CH1)  ? ch_word[1] :
                          (word_idx_reg == WORD_CRC)  ? {crc_word_i, ZERO16} :
                                                        {extra_word_i, ZERO16};

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= s_sclk;
      cs_prev_reg <= s_cs_n;
    end
  end

  // Word length is taken only between frames so a frame never changes shape
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wlen_reg <= WLEN_24;
    end else if (s_cs_n) begin
      wlen_reg <= word_length_sel_i;
    end
  end

  // Bit and word counters
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt_reg <= 5'h00;
      word_idx_reg <= WORD_RESP;
    end else if (ser_reset) begin
      bit_cnt_reg <= 5'h00;
      word_idx_reg <= WORD_RESP;
    end else if (word_done) begin
      bit_cnt_reg <= 5'h00;
      word_idx_reg <= (word_idx_reg == WORD_MAX) ? WORD_MAX : word_idx_reg + 8'h01;
    end else if (sclk_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // Transmit: launch on rising SCLK
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_reg <= 32'h0000_0000;
      dout_reg <= 1'b0;
    end else if (sclk_rise && bit_cnt_reg == 5'h00) begin
      dout_reg <= next_word[31];
      tx_reg <= {next_word[30:0], 1'b0};
    end else if (sclk_rise) begin
      dout_reg <= tx_reg[31];
      tx_reg <= {tx_reg[30:0], 1'b0};
    end
  end

  // Receive: sample on falling SCLK, first 16 bits form the command
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_reg <= 32'h0000_0000;
      cmd_hold_reg <= CMD_NULL;
      cmd_got_reg <= 1'b0;
    end else if (ser_reset && !cs_rise) begin
      cmd_got_reg <= 1'b0;
    end else if (sclk_fall) begin
      rx_reg <= {rx_reg[30:0], s_din};
      if (word_idx_reg == WORD_RESP && bit_cnt_reg == CMD_LAST_BIT) begin
        cmd_hold_reg <= {rx_reg[14:0], s_din};
        cmd_got_reg <= 1'b1;
      end
    end
  end

  // Command latched at frame end; its answer leads the next frame
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_cmd_reg <= CMD_NULL;
      cmd_valid_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= cs_rise && cmd_got_reg;
      if (cs_rise && cmd_got_reg) begin
        prev_cmd_reg <= cmd_hold_reg;
      end
    end
  end

  // Frame timer, started by the first SCLK edge
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      started_reg <= 1'b0;
      to_cnt_reg <= 16'h0000;
    end else if (ser_reset) begin
      started_reg <= 1'b0;
      to_cnt_reg <= 16'h0000;
    end else if (sclk_rise || sclk_fall || started_reg) begin
      started_reg <= 1'b1;
      to_cnt_reg <= started_reg ? to_cnt_reg + 16'h0001 : 16'h0000;
    end
  end

  // Controlling channel and its phase
  wire lag_is_1  = $signed(ch1_phase_offset_i) > $signed(ch0_phase_offset_i);
  wire lead_is_1 = $signed(ch1_phase_offset_i) < $signed(ch0_phase_offset_i);
  wire sel_lag   = (ready_source_select_i == SEL_LAG);
  wire sel_any   = (ready_source_select_i == SEL_ANY);
  wire ctrl_ch   = sel_lag ? lag_is_1 : lead_is_1;
  wire ctrl_evt  = (global_chop_i || sel_any) ? |ch_result_i : ch_result_i[ctrl_ch];
  // Offsets are forced off in global chop
  wire [9:0] ctrl_phase = global_chop_i ? 10'h000 :
                          (ctrl_ch ? ch1_phase_offset_i : ch0_phase_offset_i);

  wire [9:0] bnd = (oversampling_ratio_i == RATIO_64)  ? BND_64  :
                   (oversampling_ratio_i == RATIO_128) ? BND_128 :
                   (oversampling_ratio_i == RATIO_256) ? BND_256 :
                   (oversampling_ratio_i == RATIO_512) ? BND_512 : BND_1024;
  wire has_bnd  = (oversampling_ratio_i <= RATIO_1024);
  wire first_ok = !has_bnd || ($signed(ctrl_phase) > $signed(bnd));

  // First result after restart is dropped when the phase sits too early
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arm_reg <= 1'b0;
    end else if (restart_i) begin
      arm_reg <= 1'b1;
    end else if (ctrl_evt) begin
      arm_reg <= 1'b0;
    end
  end

  wire ready_evt = current_detect_i ? cd_hit_i :
                   (ctrl_evt && !(arm_reg && !first_ok));
  wire reading   = started_reg && !s_cs_n &&
                   (word_idx_reg == WORD_CH0 || word_idx_reg == WORD_CH1);
  wire read_done = word_done && (word_idx_reg == WORD_CH1);

  logic ready_n;
  acr_ready_gen u_ready (
    .ref_clk_i   (ref_clk_i),
    .arst_n_i    (arst_n_i),
    .event_i     (ready_evt),
    .reading_i   (reading),
    .read_done_i (read_done),
    .pulse_fmt_i (ready_pulse_format_i),
    .ready_n_o   (ready_n)
  );

  // Open drain only drives the low level
  assign conversion_ready_n_o  = ready_n;
  assign conversion_ready_oe_o = !ready_open_drain_i || !ready_n;
  assign dout_o       = dout_reg;
  assign dout_oe_o    = !s_cs_n;
  assign cmd_word_o   = prev_cmd_reg;
  assign cmd_valid_o  = cmd_valid_reg;
  assign word_index_o = word_idx_reg;
  assign data_flags_o = flags_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_cs_reset: assert property (
    s_cs_n |-> !dout_oe_o ##1 (bit_cnt_reg == 5'h00 && word_idx_reg == WORD_RESP))
    else $error("serial state not reset while deselected");
  a_timeout_reset: assert property (
    to_hit |=> (bit_cnt_reg == 5'h00 && word_idx_reg == WORD_RESP && !started_reg))
    else $error("timeout did not reset serial state");
  a_flag_set: assert property (
    ch_result_i[0] |=> data_flags_o[0])
    else $error("channel flag not set on result");
  a_first_skip: assert property (
    (arm_reg && ctrl_evt && !first_ok && !current_detect_i) |-> !ready_evt)
    else $error("early first ready not deferred");
  a_open_drain: assert property (
    (ready_open_drain_i && conversion_ready_n_o) |-> !conversion_ready_oe_o)
    else $error("open drain drives high");
  a_cmd_latch: assert property (
    (cs_rise && cmd_got_reg) |=> (cmd_valid_o && cmd_word_o == $past(cmd_hold_reg)) ##1 !cmd_valid_o)
    else $error("command not latched at frame end");
  a_wlen_16: assert property (
    (sclk_rise && bit_cnt_reg == 5'h00 && word_idx_reg == WORD_CH0 && wlen_reg == WLEN_16)
      |=> tx_reg[15:0] == 16'h0000)
    else $error("16-bit data word not truncated");
  a_push_pull: assert property (
    !ready_open_drain_i |-> conversion_ready_oe_o)
    else $error("push-pull ready not driven");
  a_wlen_frame: assert property (
    !s_cs_n |=> $stable(wlen_reg))
    else $error("word length changed inside frame");
  c_frame_end: cover property (cmd_valid_o);
  c_timeout: cover property (to_hit);
  c_crc_word: cover property (word_done && word_idx_reg == WORD_CRC);
endmodule
`default_nettype wire

//--- design/acr_pkg.sv
// Constants for the conversion-ready and serial frame logic
`default_nettype none
package acr_pkg;
  localparam int unsigned REF_CLK_MHZ = 50;
  localparam int unsigned PULSE_NS = 160;
  localparam int unsigned GAP_NS = 40;
  localparam int unsigned PULSE_CYC = (PULSE_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_CYC = (GAP_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int unsigned TIMEOUT_MCLK_CYC = 32768;

  localparam logic [1:0] WLEN_16 = 2'h0;
  localparam logic [1:0] WLEN_24 = 2'h1;
  localparam logic [1:0] WLEN_32Z = 2'h2;
  localparam logic [1:0] WLEN_32S = 2'h3;
  localparam logic [4:0] LAST_BIT_16 = 5'h0F;
  localparam logic [4:0] LAST_BIT_24 = 5'h17;
  localparam logic [4:0] LAST_BIT_32 = 5'h1F;
  localparam logic [4:0] CMD_LAST_BIT = 5'h0F;

  localparam logic [1:0] SEL_LAG = 2'h0;
  localparam logic [1:0] SEL_ANY = 2'h1;

  localparam logic [2:0] RATIO_64 = 3'h0;
  localparam logic [2:0] RATIO_128 = 3'h1;
  localparam logic [2:0] RATIO_256 = 3'h2;
  localparam logic [2:0] RATIO_512 = 3'h3;
  localparam logic [2:0] RATIO_1024 = 3'h4;
  localparam logic [9:0] BND_64 = 10'h00D;
  localparam logic [9:0] BND_128 = 10'h3ED;
  localparam logic [9:0] BND_256 = 10'h3AD;
  localparam logic [9:0] BND_512 = 10'h32D;
  localparam logic [9:0] BND_1024 = 10'h22D;

  localparam logic [7:0] WORD_RESP = 8'h00;
  localparam logic [7:0] WORD_CH0 = 8'h01;
  localparam logic [7:0] WORD_CH1 = 8'h02;
  localparam logic [7:0] WORD_CRC = 8'h03;
  localparam logic [7:0] WORD_MAX = 8'hFF;
  localparam logic [15:0] CMD_NULL = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] ZERO8 = 8'h00;

  typedef enum logic [1:0] {RG_IDLE, RG_LOW, RG_GAP, RG_PULSE} acr_rg_e;
endpackage
`default_nettype wire

//--- design/acr_ready_gen.sv
// Ready output sequencer: level and pulse formats
`timescale 1ns/10ps
`default_nettype none
module acr_ready_gen
  import acr_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  input  wire logic event_i,
  input  wire logic reading_i,
  input  wire logic read_done_i,
  input  wire logic pulse_fmt_i,
  output logic      ready_n_o
);
  acr_rg_e    st_reg;
  acr_rg_e    st_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       unread_reg;
  logic       unread_next;
  logic       ready_n_reg;
  wire        evt_ok = event_i && !reading_i;

  always_comb begin
    st_next = st_reg;
    cnt_next = (cnt_reg == 4'h0) ? 4'h0 : cnt_reg - 4'h1;
    unread_next = read_done_i ? 1'b0 : unread_reg;
    case (st_reg)
      RG_IDLE: begin
        if (evt_ok && pulse_fmt_i) begin
          if (unread_reg) begin
            unread_next = 1'b0;
          end else begin
            st_next = RG_PULSE;
            cnt_next = 4'(PULSE_CYC - 1);
            unread_next = 1'b1;
          end
        end else if (evt_ok) begin
          st_next = RG_LOW;
        end
      end
      RG_LOW: begin
        if (evt_ok) begin
          st_next = RG_GAP;
          cnt_next = 4'(GAP_CYC - 1);
        end else if (read_done_i) begin
          st_next = RG_IDLE;
        end
      end
      RG_GAP: begin
        if (cnt_reg == 4'h0) begin
          st_next = RG_LOW;
        end
      end
      RG_PULSE: begin
        if (cnt_reg == 4'h0) begin
          st_next = RG_IDLE;
        end
      end
      default: st_next = RG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= RG_IDLE;
      cnt_reg <= 4'h0;
      unread_reg <= 1'b0;
      ready_n_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      unread_reg <= unread_next;
      ready_n_reg <= !(st_next == RG_LOW || st_next == RG_PULSE);
    end
  end

  assign ready_n_o = ready_n_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_pulse_shape: assert property (
    (st_reg == RG_IDLE && evt_ok && pulse_fmt_i && !unread_reg)
      |=> (!ready_n_o)[*8] ##1 ready_n_o)
    else $error("ready pulse has wrong width");
  a_skip_unread: assert property (
    (st_reg == RG_IDLE && evt_ok && pulse_fmt_i && unread_reg) |=> ready_n_o)
    else $error("unread result not skipped");
  a_block_reading: assert property (
    (st_reg == RG_IDLE && event_i && reading_i && !read_done_i) |=> ready_n_o)
    else $error("ready asserted during readout");
  a_level_release: assert property (
    (st_reg == RG_LOW && read_done_i && !evt_ok) |=> ready_n_o)
    else $error("level ready not released after read");
  a_level_gap: assert property (
    (st_reg == RG_LOW && evt_ok) |=> ready_n_o ##2 !ready_n_o)
    else $error("level gap wrong");
  c_pulse_seen: cover property (st_reg == RG_PULSE);
  c_gap_seen: cover property (st_reg == RG_GAP);
endmodule
`default_nettype wire

//--- design/acr_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module acr_sync
  import acr_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Idle level 1 for chip select keeps the port quiet out of reset
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          meta_reg[g] <= 1'b1;
          sync_reg[g] <= 1'b1;
        end else begin
          meta_reg[g] <= async_i[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_reg;
endmodule
`default_nettype wire

//--- test/acr_host_model.sv
// Behavioural SPI master host that drives frames into the block
`timescale 1ns/10ps
`default_nettype none
module acr_host_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i,
  input  wire logic dout_oe_i
);
  logic [31:0] rx_q [0:7];
  logic        last_q = 1'b0;
  wire  logic  line_w;
  // Released output must not look like valid data
  always @(dout_i or dout_oe_i) if (dout_oe_i === 1'b1) last_q = dout_i;
  assign line_w = (dout_oe_i === 1'b1) ? dout_i : ~last_q;
  initial sclk_o = 1'b0;
  initial cs_n_o = 1'b1;
  initial din_o = 1'b0;
  task automatic frame(input int nwords, input int nbits, input logic [15:0] cmd);
    logic [31:0] tx;
    cs_n_o = 1'b0;
    #160;
    for (int w = 0; w < nwords; w++) begin
      tx = (w == 0) ? {cmd, 16'h0000} : 32'h0000_0000;
      rx_q[w] = 32'h0000_0000;
      for (int b = 0; b < nbits; b++) begin
        sclk_o = 1'b1;
        din_o = tx[31-b];
        #80;
        sclk_o = 1'b0;
        #80;
        // Sampled late: output lags SCLK by several reference clocks
        rx_q[w][nbits-1-b] = line_w;
      end
    end
    #80;
    cs_n_o = 1'b1;
    din_o = ~din_o;
    #200;
  endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the conversion-ready and frame logic
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import acr_pkg::*;
;
  localparam int TO_CYC = 64;
  // Ratio code, controlling phase, assertion expected
  localparam logic [13:0] FIRST_CASES [9] = '{{RATIO_64, 10'h00D, 1'b0}, {RATIO_64, 10'h00E, 1'b1},
    {RATIO_128, 10'h3ED, 1'b0}, {RATIO_128, 10'h3EE, 1'b1}, {RATIO_256, 10'h3AD, 1'b0},
    {RATIO_512, 10'h32D, 1'b0}, {RATIO_1024, 10'h22D, 1'b0}, {RATIO_1024, 10'h22E, 1'b1},
    {3'h5, 10'h201, 1'b1}};
  logic        ref_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  wire  logic  sclk, cs_n, din;
  logic        dout, dout_oe, rdy_n, rdy_oe, cmd_valid;
  logic [15:0] cmd_word;
  logic [7:0]  word_idx;
  logic [1:0]  flags;
  logic [1:0]  ch_res = 2'b00, sel = 2'b00, wlen = WLEN_24;
  logic [23:0] ch0_d = 24'h000000, ch1_d = 24'h000000;
  logic [9:0]  ph0 = 10'h000, ph1 = 10'h000;
  logic [2:0]  ratio = RATIO_64;
  logic        restart = 1'b0, gchop = 1'b0, cdm = 1'b0, cd_hit = 1'b0, od = 1'b0, fmt = 1'b0, to_en = 1'b0;
  logic [15:0] resp = 16'h0000, crc = 16'h0000, extra = 16'h0000;
  int          error_cnt = 0, n_checks = 0, n_valid = 0;

  acr_frame_ready #(.TIMEOUT_CYC(TO_CYC)) dut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .dout_o(dout), .dout_oe_o(dout_oe), .conversion_ready_n_o(rdy_n), .conversion_ready_oe_o(rdy_oe),
    .ch_result_i(ch_res), .ch0_data_i(ch0_d), .ch1_data_i(ch1_d), .ch0_phase_offset_i(ph0),
    .ch1_phase_offset_i(ph1), .restart_i(restart), .global_chop_i(gchop), .current_detect_i(cdm),
    .cd_hit_i(cd_hit), .oversampling_ratio_i(ratio), .ready_source_select_i(sel), .ready_open_drain_i(od),
    .ready_pulse_format_i(fmt), .word_length_sel_i(wlen), .timeout_en_i(to_en), .resp_word_i(resp),
    .crc_word_i(crc), .extra_word_i(extra), .cmd_word_o(cmd_word), .cmd_valid_o(cmd_valid),
    .word_index_o(word_idx), .data_flags_o(flags));
  acr_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout), .dout_oe_i(dout_oe));

  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (cmd_valid === 1'b1) n_valid <= n_valid + 1;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset();
    @(negedge ref_clk_i);
    arst_n_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
  endtask
  task automatic pulse_ev(input logic [1:0] ev);
    @(negedge ref_clk_i);
    ch_res = ev;
    cd_hit = (ev == 2'b00);
    @(negedge ref_clk_i);
    ch_res = 2'b00;
    cd_hit = 1'b0;
  endtask
  // Notes whether ready was seen low or high over n clocks
  task automatic watch(input int n, output logic lo, output logic hi);
    lo = (rdy_n === 1'b0);
    hi = (rdy_n === 1'b1);
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
      if (rdy_n === 1'b0) lo = 1'b1;
      if (rdy_n === 1'b1) hi = 1'b1;
    end
  endtask
  task automatic run(input int nw, input int nb, input logic [15:0] cmd);
    repeat (3) @(negedge ref_clk_i);
    #7;
    host.frame(nw, nb, cmd);
  endtask
  task automatic trial(input logic [1:0] s, input logic g, input logic rs, input logic [1:0] ev, input logic exp);
    logic lo, hi;
    do_reset();
    sel = s;
    gchop = g;
    cdm = (ev == 2'b00);
    if (rs) begin
      restart = 1'b1;
      @(negedge ref_clk_i);
      restart = 1'b0;
    end
    pulse_ev(ev);
    watch(3, lo, hi);
    chk("ready asserted", {31'h0, exp}, {31'h0, lo});
  endtask

  task automatic test_frames();
    logic [31:0] d0;
    int nb;
    do_reset();
    ch0_d = 24'h812345;
    ch1_d = 24'h7EDCBA;
    resp = 16'hC3A5;
    crc = 16'h5AF0;
    extra = 16'h9E17;
    run(4, 24, 16'hA001);
    chk("status word", {8'h0, 6'h0, WLEN_24, 6'h0, 2'b00, 8'h00}, host.rx_q[0]);
    chk("channel 1 word", {8'h0, ch1_d}, host.rx_q[2]);
    for (int w = 0; w < 4; w++) begin
      wlen = w[1:0];
      nb = (w == 0) ? 16 : (w == 1) ? 24 : 32;
      d0 = (w == 0) ? {16'h0, ch0_d[23:8]} : (w == 1) ? {8'h0, ch0_d} :
           (w == 2) ? {ch0_d, 8'h00} : {{8{ch0_d[23]}}, ch0_d};
      run(5, nb, 16'hA001);
      chk("response word", {16'h0, resp} << (nb - 16), host.rx_q[0]);
      chk("channel 0 word", d0, host.rx_q[1]);
      chk("crc word", {16'h0, crc} << (nb - 16), host.rx_q[3]);
      chk("extra word", {16'h0, extra} << (nb - 16), host.rx_q[4]);
      chk("command latched", {16'h0, 16'hA001}, {16'h0, cmd_word});
    end
    chk("command pulses", 32'd5, n_valid);
    $display("test_frames done");
  endtask
  task automatic test_timeout();
    int v;
    wlen = WLEN_16;
    to_en = 1'b1;
    v = n_valid;
    run(1, 16, 16'h1234);
    chk("pulses after timeout", v, n_valid);
    chk("command kept", {16'h0, 16'hA001}, {16'h0, cmd_word});
    to_en = 1'b0;
    run(1, 16, 16'h1234);
    chk("command without timeout", {16'h0, 16'h1234}, {16'h0, cmd_word});
    $display("test_timeout done");
  endtask
  task automatic test_level();
    logic lo, hi;
    do_reset();
    sel = SEL_ANY;
    od = 1'b1;
    wlen = WLEN_24;
    @(negedge ref_clk_i);
    chk("drive enable idle", 32'd0, {31'h0, rdy_oe});
    pulse_ev(2'b01);
    watch(3, lo, hi);
    chk("ready level", 32'd1, {31'h0, lo});
    chk("drive enable low", 32'd1, {31'h0, rdy_oe});
    chk("channel flags", 32'd1, {30'h0, flags});
    pulse_ev(2'b10);
    watch(4, lo, hi);
    chk("brief high", 32'd1, {31'h0, hi});
    chk("low again", 32'd0, {31'h0, rdy_n});
    run(4, 24, 16'h0000);
    chk("flags in status", {8'h0, 6'h0, WLEN_24, 6'h0, 2'b11, 8'h00}, host.rx_q[0]);
    chk("ready after read", 32'd1, {31'h0, rdy_n});
    // Ready is idle; event lands inside the channel 0 word of the readout
    fork
      run(4, 24, 16'h0000);
      begin
        #(160 * 34 + 140);
        pulse_ev(2'b01);
        watch(3, lo, hi);
        chk("ready during readout", 32'd0, {31'h0, lo});
        chk("word index", {24'h0, WORD_CH0}, {24'h0, word_idx});
      end
    join
    od = 1'b0;
    $display("test_level done");
  endtask
  task automatic test_source();
    ph0 = 10'h005;
    ph1 = 10'h3FB;
    for (int s = 0; s < 4; s++) begin
      trial(s[1:0], 1'b0, 1'b0, 2'b01, s <= 1);
      trial(s[1:0], 1'b0, 1'b0, 2'b10, s != 0);
    end
    trial(SEL_LAG, 1'b1, 1'b0, 2'b10, 1'b1);
    trial(SEL_LAG, 1'b0, 1'b0, 2'b00, 1'b1);
    $display("test_source done");
  endtask
  task automatic test_first();
    ph1 = 10'h200;
    for (int i = 0; i < 9; i++) begin
      ratio = FIRST_CASES[i][13:11];
      ph0 = FIRST_CASES[i][10:1];
      trial(SEL_LAG, 1'b0, 1'b1, 2'b01, FIRST_CASES[i][0]);
    end
    ratio = RATIO_64;
    $display("test_first done");
  endtask
  task automatic test_pulse();
    logic lo, hi;
    int low;
    do_reset();
    sel = SEL_ANY;
    fmt = 1'b1;
    pulse_ev(2'b01);
    low = (rdy_n === 1'b0);
    repeat (20) begin
      @(posedge ref_clk_i);
      #1;
      if (rdy_n === 1'b0) low++;
    end
    chk("pulse width", PULSE_CYC, low);
    pulse_ev(2'b01);
    watch(12, lo, hi);
    chk("skipped pulse", 32'd0, {31'h0, lo});
    pulse_ev(2'b01);
    watch(3, lo, hi);
    chk("pulse after skip", 32'd1, {31'h0, lo});
    fmt = 1'b0;
    $display("test_pulse done");
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #1_000_000;
    error_cnt++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    test_frames();
    test_timeout();
    test_level();
    test_source();
    test_first();
    test_pulse();
    finish_test();
  end
endmodule
`default_nettype wire
